// ===== hdl/pdcs_defs.vh
/*
 * constants of the device control / device status register bank:
 * bus addresses, field positions, reset values and bus encodings.
 * assumes it is included by bare name from every design file that
 * needs it; holds definitions only.
 */
`ifndef PDCS_DEFS_VH
`define PDCS_DEFS_VH

// bus address width (configuration space window)
`define PDCS_ADDR_W          12

// byte addresses of the word registers
`define PDCS_DEVCTL_ADDR     12'h0e8
`define PDCS_IRQ_STAT_ADDR   12'h100
`define PDCS_IRQ_MASK_ADDR   12'h104

// control half, low 16 bits of the word at 0xe8
`define PDCS_ERR_EN_LSB      0
`define PDCS_ERR_EN_MSB      3
`define PDCS_MPS_LSB         5
`define PDCS_MPS_MSB         7
`define PDCS_AUX_PM_BIT      10

// status half, high 16 bits of the word at 0xe8
`define PDCS_STA_ERR_LSB     16
`define PDCS_STA_ERR_MSB     19
`define PDCS_AUX_DET_BIT     20

// error categories, one bit each, in this order everywhere
`define PDCS_ERR_W           4

// interrupt status / mask layout: bits 3:0 errors, bit 4 aux change
`define PDCS_IRQ_W           5
`define PDCS_IRQ_AUX_BIT     4

// reset values
`define PDCS_ERR_EN_RST      4'h0
`define PDCS_MPS_RST         3'h0
`define PDCS_AUX_PM_RST      1'b0
`define PDCS_AUX_DET_RST     1'b1
`define PDCS_IRQ_MASK_RST    5'h00

// ahb-lite encodings
`define PDCS_HTRANS_NONSEQ   2'h2
`define PDCS_HRESP_OKAY      1'b0

`endif

// ===== hdl/pdcs_sync2.v
/*
 * two flip-flop synchroniser for a single level from a pin.
 * assumes the input is asynchronous to the core clock; only the
 * second stage may be read by other logic.
 */
`timescale 1ns/1ns

module pdcs_sync2 #(
   parameter RST_VAL = 1'b0
) (
   input  wire i_clk,
   input  wire i_srst,
   input  wire i_async,
   output wire o_sync
);

   reg meta_r;
   reg sync_r;

   // reset loads the documented idle level so readers see it at once
   always @(posedge i_clk) begin
      if (i_srst) begin
         meta_r <= RST_VAL;
         sync_r <= RST_VAL;
      end else begin
         meta_r <= i_async;
         sync_r <= meta_r;
      end
   end

   assign o_sync = sync_r;

endmodule

// ===== hdl/pdcs_top.v
/*
 * device control and device status register word of the pcie
 * capability, with error logging, error message gating, payload size
 * clamping, a sticky aux power enable and an interrupt summary, all
 * reached over an ahb-lite slave port.
 * assumes one ahb-lite master, single whole-word transfers, error
 * events as one-cycle pulses on the core clock, the aux power sense
 * as an asynchronous pin, and a cold reset that only power-up drives.
 */
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ns
`include "pdcs_defs.vh"

module pdcs_top #(
   parameter [2:0] MPS_SUPPORTED = 3'h1
) (
   input  wire                     I_CORE_CLK,
   input  wire                     I_SRST,
   input  wire                     I_COLD_SRST,
   input  wire                     I_HSEL,
   input  wire [`PDCS_ADDR_W-1:0]  I_HADDR,
   input  wire [1:0]               I_HTRANS,
   input  wire                     I_HWRITE,
   input  wire [2:0]               I_HSIZE,
   input  wire [31:0]              I_HWDATA,
   input  wire                     I_HREADY,
   output wire [31:0]              O_HRDATA,
   output wire                     O_HREADYOUT,
   output wire                     O_HRESP,
   input  wire [`PDCS_ERR_W-1:0]   I_ERR_DET,
   input  wire                     I_AUX_PWR_PIN,
   output wire [`PDCS_ERR_W-1:0]   O_ERR_MSG,
   output wire [`PDCS_ERR_W-1:0]   O_ERR_REPORT_EN,
   output wire [2:0]               O_MAX_PAYLOAD,
   output wire                     O_AUX_PM_EN,
   output wire                     O_IRQ
);

   // any reset clears the ordinary state; only cold reset the sticky bit
   wire                    srst_any;

   // bus slave state
   reg                     wr_pend_r;
   reg  [`PDCS_ADDR_W-1:0] wr_addr_r;
   reg                     rd_late_r;
   reg  [`PDCS_ADDR_W-1:0] rd_addr_r;
   reg  [31:0]             hrdata_r;
   reg                     hreadyout_r;
   reg                     hresp_r;

   // control fields
   reg  [`PDCS_ERR_W-1:0]  err_en_r;
   reg  [2:0]              mps_r;
   reg  [2:0]              mps_nxt;
   reg                     aux_pm_r;

   // status, event and interrupt state
   wire [`PDCS_ERR_W-1:0]  sta_err;
   wire                    aux_det;
   reg                     aux_det_d_r;
   reg  [`PDCS_ERR_W-1:0]  err_msg_r;
   reg  [`PDCS_IRQ_W-1:0]  irq_mask_r;
   wire [`PDCS_IRQ_W-1:0]  irq_stat;
   reg                     irq_r;

   // decoded bus events
   wire                    acc;
   wire                    rd_acc;
   wire                    wr_acc;
   wire                    wr_fire;
   wire                    wr_devctl;
   wire                    wr_irq_stat;
   wire                    wr_irq_mask;
   wire [`PDCS_ERR_W-1:0]  sta_clr;
   wire [`PDCS_IRQ_W-1:0]  irq_set;
   wire [`PDCS_IRQ_W-1:0]  irq_clr;
   wire                    aux_chg;

   // read path
   wire [`PDCS_ADDR_W-1:0] rd_sel_addr;
   reg  [31:0]             rd_word;
   wire [31:0]             devctl_word;

   // the sticky enable has its own reset path further down; everything
   // else, bus state included, drops on either reset
   assign srst_any = I_SRST | I_COLD_SRST;

   // address phase decode; hsize is not checked, whole words only
   assign acc    = I_HSEL & (I_HTRANS == `PDCS_HTRANS_NONSEQ) & I_HREADY;
   assign rd_acc = acc & ~I_HWRITE;
   assign wr_acc = acc & I_HWRITE;

   // a write takes effect at the edge that ends its data phase
   assign wr_fire     = wr_pend_r & I_HREADY;
   assign wr_devctl   = wr_fire & (wr_addr_r == `PDCS_DEVCTL_ADDR);
   assign wr_irq_stat = wr_fire & (wr_addr_r == `PDCS_IRQ_STAT_ADDR);
   assign wr_irq_mask = wr_fire & (wr_addr_r == `PDCS_IRQ_MASK_ADDR);

   // ahb-lite address and data phase tracking
   always @(posedge I_CORE_CLK) begin
      if (srst_any) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= {`PDCS_ADDR_W{1'b0}};
         rd_late_r <= 1'b0;
         rd_addr_r <= {`PDCS_ADDR_W{1'b0}};
      end else begin
         if (wr_fire) begin
            wr_pend_r <= 1'b0;
         end
         if (wr_acc) begin
            wr_pend_r <= 1'b1;
            wr_addr_r <= I_HADDR;
         end
         // a read right behind a write would see stale data: defer it
         rd_late_r <= rd_acc & wr_fire;
         if (rd_acc) begin
            rd_addr_r <= I_HADDR;
         end
      end
   end

   // hrdata and hready come from flops; one wait state only after a
   // write, traded for a register-stable output and no read bypass
   always @(posedge I_CORE_CLK) begin
      if (srst_any) begin
         hrdata_r    <= 32'h0000_0000;
         hreadyout_r <= 1'b1;
         hresp_r     <= `PDCS_HRESP_OKAY;
      end else begin
         hresp_r <= `PDCS_HRESP_OKAY;
         if (rd_acc & wr_fire) begin
            hreadyout_r <= 1'b0;
         end else if (rd_late_r) begin
            hrdata_r    <= rd_word;
            hreadyout_r <= 1'b1;
         end else if (rd_acc) begin
            hrdata_r    <= rd_word;
            hreadyout_r <= 1'b1;
         end else begin
            hreadyout_r <= 1'b1;
         end
      end
   end

   // a deferred read uses the address it latched, since the bus may
   // already show the next address phase by then
   assign rd_sel_addr = rd_late_r ? rd_addr_r : I_HADDR;

   // the shared control / status word; unused bits are tied zero
   assign devctl_word = {
      10'h000,                 // reserved 31:22
      1'b0,                    // transactions pending
      aux_det,                 // aux power present
      sta_err,                 // error detected 19:16
      1'b0,                    // reserved 15
      3'h0,                    // read request size
      1'b0,                    // no snoop
      aux_pm_r,                // aux power enable
      1'b0,                    // phantom functions
      1'b0,                    // extended tag
      mps_r,                   // max payload
      1'b0,                    // relaxed ordering
      err_en_r                 // reporting enables
   };

   // read mux; unmapped addresses read zero with an okay response
   always @* begin
      rd_word = 32'h0000_0000;
      case (rd_sel_addr)
         `PDCS_DEVCTL_ADDR: begin
            rd_word = devctl_word;
         end
         `PDCS_IRQ_STAT_ADDR: begin
            rd_word = {27'h000_0000, irq_stat};
         end
         `PDCS_IRQ_MASK_ADDR: begin
            rd_word = {27'h000_0000, irq_mask_r};
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   // payload code above the supported maximum is clamped, not stored
   always @* begin
      mps_nxt = I_HWDATA[`PDCS_MPS_MSB:`PDCS_MPS_LSB];
      if (I_HWDATA[`PDCS_MPS_MSB:`PDCS_MPS_LSB] > MPS_SUPPORTED) begin
         mps_nxt = MPS_SUPPORTED;
      end
   end

   // writable control fields; other written bits are dropped
   always @(posedge I_CORE_CLK) begin
      if (srst_any) begin
         err_en_r <= `PDCS_ERR_EN_RST;
         mps_r    <= `PDCS_MPS_RST;
      end else if (wr_devctl) begin
         err_en_r <= I_HWDATA[`PDCS_ERR_EN_MSB:`PDCS_ERR_EN_LSB];
         mps_r    <= mps_nxt;
      end
   end

   // aux power enable survives the conventional reset on purpose
   always @(posedge I_CORE_CLK) begin
      if (I_COLD_SRST) begin
         aux_pm_r <= `PDCS_AUX_PM_RST;
      end else if (wr_devctl) begin
         aux_pm_r <= I_HWDATA[`PDCS_AUX_PM_BIT];
      end
   end

   // error logging ignores the enables; write one to clear
   assign sta_clr = wr_devctl ?
                    I_HWDATA[`PDCS_STA_ERR_MSB:`PDCS_STA_ERR_LSB] :
                    {`PDCS_ERR_W{1'b0}};

   pdcs_w1c_flag #(
      .W     (`PDCS_ERR_W)
   ) u_sta_err (
      .i_clk (I_CORE_CLK),
      .i_srst(srst_any),
      .i_set (I_ERR_DET),
      .i_clr (sta_clr),
      .o_q   (sta_err)
   );

   // aux power sense arrives from a pin; it idles at present
   pdcs_sync2 #(
      .RST_VAL (`PDCS_AUX_DET_RST)
   ) u_aux_sync (
      .i_clk   (I_CORE_CLK),
      .i_srst  (srst_any),
      .i_async (I_AUX_PWR_PIN),
      .o_sync  (aux_det)
   );

   // previous aux level, for the change event of the interrupt
   always @(posedge I_CORE_CLK) begin
      if (srst_any) begin
         aux_det_d_r <= `PDCS_AUX_DET_RST;
      end else begin
         aux_det_d_r <= aux_det;
      end
   end

   // either edge of the synchronised level counts; the pin itself is
   // never read here, so no metastable value can reach the flag
   assign aux_chg = aux_det ^ aux_det_d_r;

   // messages only for enabled categories, using the enable as it
   // stands in the event cycle; several kinds may fire together
   always @(posedge I_CORE_CLK) begin
      if (srst_any) begin
         err_msg_r <= {`PDCS_ERR_W{1'b0}};
      end else begin
         err_msg_r <= I_ERR_DET & err_en_r;
      end
   end

   // interrupt status: errors in 3:0, aux power change in bit 4
   assign irq_set = {aux_chg, I_ERR_DET};
   assign irq_clr = wr_irq_stat ? I_HWDATA[`PDCS_IRQ_W-1:0] :
                    {`PDCS_IRQ_W{1'b0}};

   pdcs_w1c_flag #(
      .W     (`PDCS_IRQ_W)
   ) u_irq_stat (
      .i_clk (I_CORE_CLK),
      .i_srst(srst_any),
      .i_set (irq_set),
      .i_clr (irq_clr),
      .o_q   (irq_stat)
   );

   // mask register and registered level interrupt
   always @(posedge I_CORE_CLK) begin
      if (srst_any) begin
         irq_mask_r <= `PDCS_IRQ_MASK_RST;
         irq_r      <= 1'b0;
      end else begin
         if (wr_irq_mask) begin
            irq_mask_r <= I_HWDATA[`PDCS_IRQ_W-1:0];
         end
         irq_r <= |(irq_stat & irq_mask_r);
      end
   end

   // every output is a plain flop, no logic between register and pin
   assign O_HRDATA        = hrdata_r;
   assign O_HREADYOUT     = hreadyout_r;
   assign O_HRESP         = hresp_r;
   assign O_ERR_MSG       = err_msg_r;
   assign O_ERR_REPORT_EN = err_en_r;
   assign O_MAX_PAYLOAD   = mps_r;
   assign O_AUX_PM_EN     = aux_pm_r;
   assign O_IRQ           = irq_r;

endmodule

// ===== hdl/pdcs_w1c_flag.v
/*
 * vector of sticky event flags, set by hardware, cleared by a one
 * written by software. assumes set and clear come from core-clock
 * logic; a set in the same cycle as its clear wins.
 */
`timescale 1ns/1ns

module pdcs_w1c_flag #(
   parameter W = 4
) (
   input  wire         i_clk,
   input  wire         i_srst,
   input  wire [W-1:0] i_set,
   input  wire [W-1:0] i_clr,
   output wire [W-1:0] o_q
);

   reg  [W-1:0] q_r;
   wire [W-1:0] q_nxt;

   // set after clear so a simultaneous event is never lost
   assign q_nxt = (q_r & ~i_clr) | i_set;

   always @(posedge i_clk) begin
      if (i_srst) begin
         q_r <= {W{1'b0}};
      end else begin
         q_r <= q_nxt;
      end
   end

   assign o_q = q_r;

endmodule

// ===== test/pdcs_ahb_mst.sv
/* ahb-lite master standing for the configuration requester.
   assumes xfer is called just after a rising clock edge. */
`timescale 1ns/1ns
module pdcs_ahb_mst (
   input  wire         clk,
   input  wire         hready,
   input  wire  [31:0] hrdata,
   output logic        hsel,
   output logic [11:0] haddr,
   output logic [1:0]  htrans,
   output logic        hwrite,
   output logic [2:0]  hsize,
   output logic [31:0] hwdata,
   output logic [31:0] rd_val,
   output int          rd_cnt
);
   // idle bus until the first request
   initial begin
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = 32'h0000_0000;
      rd_val = 32'h0000_0000;
      rd_cnt = 0;
   end
   // one single transfer; each phase held until hready is sampled high
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'h2;
      @(posedge clk);
      while (!hready) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (!hready) @(posedge clk);
      if (!w) begin
         rd_val <= hrdata;
         rd_cnt <= rd_cnt + 1;
      end
   endtask
endmodule

// ===== test/pdcs_chk_sva.sv
/* port checker of the device control / status register word.
   assumes it is bound into pdcs_top and sees only its ports. */
`timescale 1ns/1ns
module pdcs_chk #(
   parameter [2:0] MPS_SUPPORTED = 3'h1
) (
   input wire       I_CORE_CLK,
   input wire       I_SRST,
   input wire       I_COLD_SRST,
   input wire       I_HSEL,
   input wire [1:0] I_HTRANS,
   input wire       I_HWRITE,
   input wire       I_HREADY,
   input wire       O_HREADYOUT,
   input wire       O_HRESP,
   input wire [3:0] I_ERR_DET,
   input wire [3:0] O_ERR_MSG,
   input wire [3:0] O_ERR_REPORT_EN,
   input wire [2:0] O_MAX_PAYLOAD,
   input wire       O_AUX_PM_EN,
   input wire       O_IRQ
);
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_SRST || I_COLD_SRST);
   // address phases accepted by the slave
   wire tk = I_HSEL && I_HTRANS == 2'h2 && I_HREADY;
   a_resp_okay: assert property (O_HRESP == 1'b0)
      else $error("error response seen");
   a_write_nowait: assert property (tk && I_HWRITE |=> O_HREADYOUT)
      else $error("write got a wait state");
   a_read_answer: assert property (tk && !I_HWRITE |-> ##[1:2] O_HREADYOUT)
      else $error("read answer late");
   a_mps_clamp: assert property (O_MAX_PAYLOAD <= MPS_SUPPORTED)
      else $error("payload code above supported maximum");
   a_msg_gate: assert property (O_ERR_MSG ==
      ($past(I_ERR_DET) & $past(O_ERR_REPORT_EN)))
      else $error("error message not gated by enable");
   a_en_by_write: assert property (!$stable(O_ERR_REPORT_EN)
      |-> $past(tk, 2) && $past(I_HWRITE, 2))
      else $error("enable moved without write");
   // only the power-up reset may clear the aux enable
   a_aux_sticky: assert property (@(posedge I_CORE_CLK)
      disable iff (I_COLD_SRST) I_SRST |=> $stable(O_AUX_PM_EN))
      else $error("aux enable lost in reset");
   a_ctl_reset: assert property ($fell(I_SRST) |->
      O_ERR_REPORT_EN == 4'h0 && O_MAX_PAYLOAD == 3'h0 && !O_IRQ)
      else $error("control not at reset value");
endmodule
bind pdcs_top pdcs_chk #(.MPS_SUPPORTED(MPS_SUPPORTED)) pdcs_chk_i (
   .I_CORE_CLK(I_CORE_CLK), .I_SRST(I_SRST), .I_COLD_SRST(I_COLD_SRST),
   .I_HSEL(I_HSEL), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE),
   .I_HREADY(I_HREADY), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
   .I_ERR_DET(I_ERR_DET), .O_ERR_MSG(O_ERR_MSG),
   .O_ERR_REPORT_EN(O_ERR_REPORT_EN), .O_MAX_PAYLOAD(O_MAX_PAYLOAD),
   .O_AUX_PM_EN(O_AUX_PM_EN), .O_IRQ(O_IRQ));

// ===== test/pdcs_top_bench.sv
/* self-checking bench of pdcs_top over its ahb-lite port.
   assumes the master model and the bound port checker. */
`timescale 1ns/1ns
module pdcs_top_bench;
   localparam logic [2:0] MPS = 3'h2;
   logic        clk = 1'b0, srst = 1'b1, cold = 1'b1, aux = 1'b1;
   logic [3:0]  err = 4'h0;
   logic [31:0] seed = 32'h0000_02e6, r;
   logic [31:0] expq[$];
   int          err_total = 0, checks_done = 0, k;
   wire         hsel, hwrite, hrdy, hresp, irq, aux_en;
   wire  [11:0] haddr;
   wire  [1:0]  htrans;
   wire  [31:0] hwdata, hrdata, rdv;
   wire  [3:0]  msg, ren;
   wire  [2:0]  mps, hsz;
   int          rdc, rd_seen = 0;
   pdcs_top #(.MPS_SUPPORTED(MPS)) pdcs_top_i (.I_CORE_CLK(clk),
      .I_SRST(srst), .I_COLD_SRST(cold), .I_HSEL(hsel), .I_HADDR(haddr),
      .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsz),
      .I_HWDATA(hwdata), .I_HREADY(hrdy), .O_HRDATA(hrdata),
      .O_HREADYOUT(hrdy), .O_HRESP(hresp), .I_ERR_DET(err),
      .I_AUX_PWR_PIN(aux), .O_ERR_MSG(msg), .O_ERR_REPORT_EN(ren),
      .O_MAX_PAYLOAD(mps), .O_AUX_PM_EN(aux_en), .O_IRQ(irq));
   pdcs_ahb_mst pdcs_ahb_mst_i (.clk(clk), .hready(hrdy), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hwdata(hwdata), .hsize(hsz), .rd_val(rdv), .rd_cnt(rdc));
   // free-running core clock, 4 ns
   initial begin
      forever #2 clk = ~clk;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      expq.push_back(e);
      pdcs_ahb_mst_i.xfer(1'b0, a, 32'h0000_0000);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      pdcs_ahb_mst_i.xfer(1'b1, a, d);
   endtask
   task automatic pulse(input logic [3:0] v);
      err <= v;
      @(posedge clk);
      err <= 4'h0;
   endtask
   task automatic results();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // each read result is judged against the oldest note, half a cycle
   // after the master takes it, once both of its outputs have settled
   always @(negedge clk) begin
      if (rdc != rd_seen) begin
         rd_seen <= rdc;
         chk(rdv, expq.pop_front());
      end
   end
   // hang guard, far beyond the roughly 120 cycles of the run
   initial begin
      #20000;
      err_total++;
      results();
   end
   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      cold <= 1'b0;
      @(posedge clk);
      rd(12'h0e8, 32'h0010_0000);
      rd(12'h104, 32'h0000_0000);
      rd(12'h0f0, 32'h0000_0000);
      for (k = 0; k < 8; k++) begin
         r = xs();
         wr(12'h0e8, (r & 32'hffff_ff1f) | (k << 5));
         rd(12'h0e8, (r & 32'h0000_040f) | 32'h0010_0000 |
            ((k > MPS ? MPS : k) << 5));
         chk({29'h0, mps}, (k > MPS ? MPS : k));
         chk({28'h0, ren}, r & 32'h0000_000f);
         chk({31'h0, aux_en}, (r >> 10) & 32'h0000_0001);
      end
      wr(12'h0e8, 32'h0000_0005);
      wr(12'h104, 32'h0000_000f);
      for (k = 0; k < 4; k++) begin
         pulse(4'h1 << k);
         #1 chk({28'h0, msg}, (4'h1 << k) & 4'h5);
         @(posedge clk);
         #1 chk({31'h0, irq}, 32'h0000_0001);
         @(posedge clk);
         rd(12'h0e8, 32'h0010_0005 | (32'h0001_0000 << k));
         wr(12'h0e8, 32'h0000_0005 | (32'h0001_0000 << k));
         wr(12'h100, 32'h0000_001f);
         rd(12'h0e8, 32'h0010_0005);
         chk({31'h0, irq}, 32'h0000_0000);
      end
      // masked event logs but stays quiet
      wr(12'h104, 32'h0000_0000);
      pulse(4'h8);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0000_0000);
      rd(12'h100, 32'h0000_0008);
      wr(12'h0e8, 32'h0008_0400);
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk({31'h0, aux_en}, 32'h0000_0001);
      rd(12'h0e8, 32'h0010_0400);
      aux <= 1'b0;
      repeat (4) @(posedge clk);
      rd(12'h0e8, 32'h0000_0400);
      rd(12'h100, 32'h0000_0010);
      repeat (2) @(posedge clk);
      results();
   end
endmodule
